// >>> src/lst_delay_line.v
// Fixed-depth delay line for lockstep compare paths
`timescale 1ns/1ns
`default_nettype none
module lst_delay_line #(
  parameter WIDTH = 32,
  parameter DEPTH = 2
) (
  input wire core_clk,
  input wire reset,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage_reg [0:DEPTH-1];
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_stage
      always @(posedge core_clk)
      begin
        if (reset)
          stage_reg[i] <= {WIDTH{1'b0}};
        else if (i == 0)
          stage_reg[i] <= din;
        else
          stage_reg[i] <= stage_reg[(i == 0) ? 0 : i-1];
      end
    end
  endgenerate
  assign dout = stage_reg[DEPTH-1];
endmodule // lst_delay_line
`default_nettype wire

// >>> src/lst_selftest.v
// Lockstep compare unit and CPU self-test controller with Wishbone registers
// What this block does
// - Second core clock tree equal, in phase
// - Compare both cores through differing delay paths
// - Compare delay is two clock cycles
// - Controller drives logic BIST engine on cores
// - Test split into intervals, programmable count
// - Run continues or restarts per software
// - Core under test isolated from system
// - Failing interval number recorded, readable
// - Timeout counter supervises each run
// - Processor reset after run; handler reads status
// - Self-test reset flagged in exception bit 5
// - Test clock divided, software keeps under 45MHz
// - Divider held in register at fixed address
// - Processor clocks divided one to eight, same
// - Interval 1365 test cycles, up to 26
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "lst_selftest_regs.vh"
module lst_selftest (
  input wire core_clk,
  input wire reset,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [27:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [31:0] core1_out,
  input wire [31:0] core2_out,
  input wire bist_sig_fail,
  output reg core1_clk_en,
  output reg core2_clk_en,
  output reg selftest_clock_en,
  output reg bist_enable,
  output reg bist_interval_start,
  output reg [4:0] bist_interval_num,
  output reg core_isolate,
  output reg cpu_reset,
  output reg compare_error
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_RESET = 2'h2;
  localparam [31:0] TOUT_RST = `LST_TOUT_RESET;

  reg [2:0] divide_ratio_field_reg;
  reg [4:0] count_reg;
  reg [7:0] timeout_lane_reg [0:3];
  wire [31:0] timeout_val;
  reg [4:0] fail_int_reg;
  reg done_reg;
  reg fail_reg;
  reg tout_reg;
  reg cmp_reg;
  reg exc_stc_reg;
  reg [1:0] state_reg;
  reg [4:0] next_int_reg;
  reg [4:0] run_left_reg;
  reg [15:0] cyc_reg;
  reg [31:0] tcnt_reg;
  reg [2:0] div_cnt_reg;
  reg [3:0] rst_cnt_reg;
  reg [31:0] rdata;
  wire [31:0] core1_dly;
  wire [31:0] core2_dly;
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land on the edge at which the master samples ack
  wire wr_go = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
  wire wr = wr_go & wb_sel_i[0];
  wire sel_divide_ratio_field = wb_adr_i == `LST_DIVIDE_RATIO_FIELD_ADDR;
  wire sel_ctrl = wb_adr_i == `LST_CTRL_ADDR;
  wire sel_tout = wb_adr_i == `LST_TOUT_ADDR;
  wire start_wr = wr && sel_ctrl && wb_dat_i[`LST_CTRL_START] && state_reg == ST_IDLE;
  // Count written together with start applies to this very run
  wire [4:0] start_cnt = wb_sel_i[1] ? wb_dat_i[`LST_CTRL_CNT_MSB:`LST_CTRL_CNT_LSB] : count_reg;
  wire tick = (div_cnt_reg == divide_ratio_field_reg);
  wire mismatch = (core1_dly != core2_dly) && state_reg == ST_IDLE;

  // Core 1 path delayed; core 2 runs two cycles later, so undelayed here
  lst_delay_line #(
    .WIDTH(32),
    .DEPTH(`LST_CMP_DELAY)
  ) u_dly1 (
    .core_clk(core_clk),
    .reset(reset),
    .din(core1_out),
    .dout(core1_dly)
  );
  assign core2_dly = core2_out;

  always @*
  begin
    case (wb_adr_i)
      `LST_DIVIDE_RATIO_FIELD_ADDR: rdata = {29'h0, divide_ratio_field_reg};
      `LST_CTRL_ADDR: rdata = {19'h0, count_reg, 8'h0};
      `LST_STAT_ADDR: rdata = {27'h0, state_reg != ST_IDLE, cmp_reg, tout_reg, fail_reg, done_reg};
      `LST_TOUT_ADDR: rdata = timeout_val;
      `LST_FAIL_ADDR: rdata = {27'h0, fail_int_reg};
      `LST_EXC_ADDR: rdata = {26'h0, exc_stc_reg, 5'h0};
      default: rdata = 32'h0;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req & ~wb_we_i) ? rdata : 32'h0;
    end
  end

  // Configuration registers; byte lane 0 holds the divide ratio, byte lane 1 the interval count
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      divide_ratio_field_reg <= 3'h0;
      count_reg <= 5'h1;
    end
    else if (wr_go)
    begin
      if (sel_divide_ratio_field && wb_sel_i[0])
        divide_ratio_field_reg <= wb_dat_i[`LST_DIV_MSB:`LST_DIV_LSB];
      if (sel_ctrl && wb_sel_i[1] && state_reg == ST_IDLE)
        count_reg <= wb_dat_i[`LST_CTRL_CNT_MSB:`LST_CTRL_CNT_LSB];
    end
  end

  // Timeout word, one register per byte lane
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1)
    begin : g_tout_lane
      always @(posedge core_clk)
      begin
        if (reset)
          timeout_lane_reg[lane] <= TOUT_RST[8*lane+7 -: 8];
        else if (wr_go && sel_tout && wb_sel_i[lane])
          timeout_lane_reg[lane] <= wb_dat_i[8*lane+7 -: 8];
      end
      assign timeout_val[8*lane+7 -: 8] = timeout_lane_reg[lane];
    end
  endgenerate

  // Compare flag: hardware set wins over software write-one clear
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      cmp_reg <= 1'b0;
      compare_error <= 1'b0;
    end
    else
    begin
      compare_error <= mismatch;
      if (mismatch)
        cmp_reg <= 1'b1;
      else if (wr && wb_adr_i == `LST_STAT_ADDR && wb_dat_i[`LST_STAT_CMP])
        cmp_reg <= 1'b0;
    end
  end

  // Test clock divider; ratio field + 1 gives divide by one to eight
  always @(posedge core_clk)
  begin
    if (reset || state_reg != ST_RUN)
      div_cnt_reg <= 3'h0;
    else if (tick)
      div_cnt_reg <= 3'h0;
    else
      div_cnt_reg <= div_cnt_reg + 3'h1;
  end

  // Self-test sequencer
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      state_reg <= ST_IDLE;
      next_int_reg <= 5'h0;
      run_left_reg <= 5'h0;
      cyc_reg <= 16'h0;
      tcnt_reg <= 32'h0;
      rst_cnt_reg <= 4'h0;
      fail_int_reg <= 5'h0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      tout_reg <= 1'b0;
      exc_stc_reg <= 1'b0;
      bist_interval_start <= 1'b0;
      bist_interval_num <= 5'h0;
    end
    else
    begin
      bist_interval_start <= 1'b0;
      if (wr && wb_adr_i == `LST_EXC_ADDR && wb_dat_i[`LST_EXC_STC_BIT] && state_reg != ST_RESET)
        exc_stc_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (start_wr && start_cnt != 5'h0)
          begin
            state_reg <= ST_RUN;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            tout_reg <= 1'b0;
            fail_int_reg <= 5'h0;
            cyc_reg <= 16'h0;
            tcnt_reg <= 32'h0;
            run_left_reg <= start_cnt;
            if (wb_dat_i[`LST_CTRL_RESTART] || next_int_reg >= `LST_MAX_INTERVALS)
            begin
              next_int_reg <= 5'h0;
              bist_interval_num <= 5'h0;
            end
            else
              bist_interval_num <= next_int_reg;
            bist_interval_start <= 1'b1;
          end
        end
        ST_RUN:
        begin
          tcnt_reg <= tcnt_reg + 32'h1;
          if (tcnt_reg >= timeout_val)
          begin
            tout_reg <= 1'b1;
            state_reg <= ST_RESET;
            rst_cnt_reg <= 4'h0;
          end
          else if (tick)
          begin
            if (cyc_reg == `LST_INTERVAL_CYCLES - 16'h1)
            begin
              cyc_reg <= 16'h0;
              next_int_reg <= bist_interval_num + 5'h1;
              if (bist_sig_fail)
              begin
                fail_reg <= 1'b1;
                fail_int_reg <= bist_interval_num + 5'h1;
                state_reg <= ST_RESET;
                rst_cnt_reg <= 4'h0;
              end
              else if (run_left_reg == 5'h1 || bist_interval_num + 5'h1 >= `LST_MAX_INTERVALS)
              begin
                done_reg <= 1'b1;
                state_reg <= ST_RESET;
                rst_cnt_reg <= 4'h0;
              end
              else
              begin
                run_left_reg <= run_left_reg - 5'h1;
                bist_interval_num <= bist_interval_num + 5'h1;
                bist_interval_start <= 1'b1;
              end
            end
            else
              cyc_reg <= cyc_reg + 16'h1;
          end
        end
        ST_RESET:
        begin
          exc_stc_reg <= 1'b1;
          rst_cnt_reg <= rst_cnt_reg + 4'h1;
          if (rst_cnt_reg == `LST_CPU_RST_CYCLES - 4'h1)
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Registered control outputs
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      core1_clk_en <= 1'b1;
      core2_clk_en <= 1'b1;
      selftest_clock_en <= 1'b0;
      bist_enable <= 1'b0;
      core_isolate <= 1'b0;
      cpu_reset <= 1'b0;
    end
    else
    begin
      // Both trees gated by one term so they stay in phase
      core1_clk_en <= state_reg != ST_RUN || tick;
      core2_clk_en <= state_reg != ST_RUN || tick;
      selftest_clock_en <= state_reg == ST_RUN && tick;
      bist_enable <= state_reg == ST_RUN;
      core_isolate <= state_reg == ST_RUN;
      cpu_reset <= state_reg == ST_RESET;
    end
  end
endmodule // lst_selftest
`default_nettype wire

// >>> src/lst_selftest_regs.vh
// Register offsets, fields and timing counts of the lockstep self-test block
`ifndef LST_SELFTEST_REGS_VH
`define LST_SELFTEST_REGS_VH
`define LST_DIVIDE_RATIO_FIELD_ADDR 28'hfffe108
`define LST_CTRL_ADDR 28'hfffe100
`define LST_STAT_ADDR 28'hfffe104
`define LST_TOUT_ADDR 28'hfffe10c
`define LST_FAIL_ADDR 28'hfffe110
`define LST_EXC_ADDR 28'hfffe114
`define LST_ADDR_W 28
`define LST_DIV_LSB 0
`define LST_DIV_MSB 2
`define LST_CTRL_START 0
`define LST_CTRL_RESTART 1
`define LST_CTRL_CNT_LSB 8
`define LST_CTRL_CNT_MSB 12
`define LST_STAT_DONE 0
`define LST_STAT_FAIL 1
`define LST_STAT_TOUT 2
`define LST_STAT_CMP 3
`define LST_STAT_BUSY 4
`define LST_EXC_STC_BIT 5
`define LST_INTERVAL_CYCLES 16'h0555
`define LST_MAX_INTERVALS 5'h1a
`define LST_CMP_DELAY 2
`define LST_TOUT_RESET 32'hffffffff
`define LST_CPU_RST_CYCLES 4'h8
`endif

// >>> verification/lst_core_model.sv
// Lockstep core pair and self-test signature stand-in
`timescale 1ns/1ns
`default_nettype none
module lst_core_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic inject,
  input wire logic [4:0] fail_iv,
  input wire logic bist_enable,
  input wire logic [4:0] bist_interval_num,
  output logic [31:0] core1_out,
  output logic [31:0] core2_out,
  output logic bist_sig_fail
);
  logic [31:0] lag_reg [0:1];
  always @(posedge core_clk)
  begin
    core1_out <= reset ? 32'h0 : core1_out + 32'h9e37;
    lag_reg[0] <= reset ? 32'h0 : core1_out;
    lag_reg[1] <= lag_reg[0];
  end
  // Second core trails by two cycles; inject is a commanded fault
  assign core2_out = lag_reg[1] ^ {31'h0, inject};
  assign bist_sig_fail = bist_enable && (bist_interval_num + 5'h1 == fail_iv);
endmodule // lst_core_model
`default_nettype wire

// >>> verification/lst_selftest_monitor.sv
// Port checks for the lockstep self-test block
`timescale 1ns/1ns
`default_nettype none
module lst_selftest_monitor (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [31:0] core1_out,
  input wire logic [31:0] core2_out,
  input wire logic core1_clk_en,
  input wire logic core2_clk_en,
  input wire logic selftest_clock_en,
  input wire logic bist_enable,
  input wire logic bist_interval_start,
  input wire logic [4:0] bist_interval_num,
  input wire logic core_isolate,
  input wire logic cpu_reset,
  input wire logic compare_error
);
  logic [1:0] up_reg;
  // Delayed core history is stale until three edges after reset
  always @(posedge core_clk)
  begin
    if (reset)
      up_reg <= 2'h0;
    else if (up_reg != 2'h3)
      up_reg <= up_reg + 2'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence quiet_s;
    up_reg == 2'h3 && !bist_enable && !$past(bist_enable) && !cpu_reset;
  endsequence
  sequence rst_pulse_s;
    cpu_reset [*8] ##1 !cpu_reset;
  endsequence
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data without ack");
  AST_CLK_PAIR: assert property (core1_clk_en == core2_clk_en)
    else $error("core clock trees differ");
  AST_CLK_DIV: assert property (core1_clk_en == (!bist_enable || selftest_clock_en))
    else $error("core clock not divided during run");
  AST_ISOLATE: assert property (bist_enable == core_isolate)
    else $error("isolation differs from run");
  AST_TICK_RUN: assert property (selftest_clock_en |-> bist_enable)
    else $error("test tick outside run");
  AST_NUM_MAX: assert property (bist_interval_start |-> bist_interval_num < 5'h1a)
    else $error("interval number too large");
  AST_CMP: assert property (quiet_s and $past(core1_out, 2) != core2_out |=> compare_error)
    else $error("mismatch not flagged");
  AST_RST_PULSE: assert property ($rose(cpu_reset) |-> rst_pulse_s)
    else $error("cpu reset length wrong");
  AST_RUN_END: assert property ($fell(bist_enable) |-> ##[0:2] cpu_reset)
    else $error("no cpu reset after run");
endmodule // lst_selftest_monitor
`default_nettype wire

// >>> verification/lst_selftest_tb.sv
// Self-checking bench for the lockstep self-test block
`timescale 1ns/1ns
`default_nettype none
`include "lst_selftest_regs.vh"
module lst_selftest_tb;
  logic core_clk = 1'b0, reset = 1'b1, inject = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [27:0] wb_adr_i = 28'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, rd;
  logic [4:0] fail_iv = 5'h0;
  wire logic [31:0] wb_dat_o, core1_out, core2_out;
  wire logic [4:0] bist_interval_num;
  wire logic wb_ack_o, bist_sig_fail, core1_clk_en, core2_clk_en, selftest_clock_en, bist_enable;
  wire logic bist_interval_start, core_isolate, cpu_reset, compare_error;
  int seed = 32'h6c66;
  int n_mismatch = 0, comparisons = 0, ticks = 0, starts = 0, first_num = -1, next_iv = 0, d;
  int busy = 0;
  lst_selftest DUT (
    .core_clk(core_clk),
    .reset(reset),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .core1_out(core1_out),
    .core2_out(core2_out),
    .bist_sig_fail(bist_sig_fail),
    .core1_clk_en(core1_clk_en),
    .core2_clk_en(core2_clk_en),
    .selftest_clock_en(selftest_clock_en),
    .bist_enable(bist_enable),
    .bist_interval_start(bist_interval_start),
    .bist_interval_num(bist_interval_num),
    .core_isolate(core_isolate),
    .cpu_reset(cpu_reset),
    .compare_error(compare_error)
  );
  lst_core_model PART (
    .core_clk(core_clk),
    .reset(reset),
    .inject(inject),
    .fail_iv(fail_iv),
    .bist_enable(bist_enable),
    .bist_interval_num(bist_interval_num),
    .core1_out(core1_out),
    .core2_out(core2_out),
    .bist_sig_fail(bist_sig_fail)
  );
  initial forever #4 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    ticks <= ticks + selftest_clock_en;
    starts <= starts + bist_interval_start;
    busy <= busy + bist_enable;
    if (bist_interval_start && first_num < 0)
      first_num <= bist_interval_num;
  end
  task final_report;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [27:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= v;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 64);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 64)
    begin
      n_mismatch++;
      final_report;
    end
  endtask
  task wait_rst(input logic lvl);
    int n;
    n = 0;
    while (cpu_reset !== lvl && n < 40000)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 40000)
    begin
      n_mismatch++;
      final_report;
    end
  endtask
  // Model keeps the continue point across runs
  task run(input int cnt, input logic rs, input int fiv, input logic [31:0] stat);
    int t0, s0, b0, ef;
    t0 = ticks;
    s0 = starts;
    b0 = busy;
    ef = rs ? 0 : next_iv;
    next_iv = ef + cnt;
    first_num = -1;
    fail_iv <= fiv[4:0];
    wb(1'b1, `LST_CTRL_ADDR, {19'h0, cnt[4:0], 6'h0, rs, 1'b1});
    wait_rst(1'b1);
    wait_rst(1'b0);
    if (!stat[2])
    begin
      chk(ticks - t0, cnt * 1365);
      chk(starts - s0, cnt);
      chk(busy - b0, cnt * 1365 * (d + 1));
    end
    chk(first_num, ef);
    wb(1'b0, `LST_STAT_ADDR, 32'h0);
    chk(rd & 32'hf, stat);
    wb(1'b0, `LST_FAIL_ADDR, 32'h0);
    chk(rd, fiv);
    wb(1'b0, `LST_EXC_ADDR, 32'h0);
    chk(rd & 32'h20, 32'h20);
    wb(1'b1, `LST_EXC_ADDR, 32'h20);
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    wb(1'b0, `LST_TOUT_ADDR, 32'h0);
    chk(rd, `LST_TOUT_RESET);
    wb(1'b1, 28'hfffe118, 32'hffffffff);
    wb(1'b0, 28'hfffe118, 32'h0);
    chk(rd, 32'h0);
    inject <= 1'b1;
    @(posedge core_clk);
    inject <= 1'b0;
    repeat (4) @(posedge core_clk);
    wb(1'b0, `LST_STAT_ADDR, 32'h0);
    chk(rd & 32'h8, 32'h8);
    wb(1'b1, `LST_STAT_ADDR, 32'h8);
    wb(1'b0, `LST_STAT_ADDR, 32'h0);
    chk(rd & 32'h8, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      // Ratio three or more keeps the test clock under its limit
      d = i == 0 ? 2 : 2 + {$random(seed)} % 6;
      wb(1'b1, `LST_DIVIDE_RATIO_FIELD_ADDR, d);
      wb(1'b0, `LST_DIVIDE_RATIO_FIELD_ADDR, 32'h0);
      chk(rd & 32'h7, d);
      run(i + 1, 1'b1, 2 * i, {30'h0, i[0], ~i[0]});
    end
    run(1, 1'b0, 0, 32'h1);
    wb(1'b1, `LST_TOUT_ADDR, 32'd200);
    run(26, 1'b1, 0, 32'h4);
    final_report;
  end
endmodule // lst_selftest_tb
bind lst_selftest lst_selftest_monitor MON (
  .core_clk(core_clk),
  .reset(reset),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .core1_out(core1_out),
  .core2_out(core2_out),
  .core1_clk_en(core1_clk_en),
  .core2_clk_en(core2_clk_en),
  .selftest_clock_en(selftest_clock_en),
  .bist_enable(bist_enable),
  .bist_interval_start(bist_interval_start),
  .bist_interval_num(bist_interval_num),
  .core_isolate(core_isolate),
  .cpu_reset(cpu_reset),
  .compare_error(compare_error)
);
`default_nettype wire
